// *** bench/dcfsf_peer.sv ***
// far-side writer and reader logic driving the buffer pins
`timescale 1ns/1ps
`default_nettype none
module dcfsf_peer (
   // clock and requests from the bench
   input wire logic clk_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic ft_i,
   input wire logic [17:0] data_i,
   // pins toward the buffer
   output logic wen_n_o = 1'b1,
   output logic ren_n_o = 1'b1,
   output logic mode_o = 1'b0,
   output logic [17:0] data_o = 18'h0_0000
);
   // an idle data bus toggles so a stale word never passes for a fresh one
   always @(posedge clk_i) begin
      wen_n_o <= ~wr_i;
      ren_n_o <= ~rd_i;
      mode_o <= ft_i;
      data_o <= wr_i ? data_i : ~data_o;
   end
endmodule
`default_nettype wire

// *** bench/dcfsf_top_sva.sv ***
// output checks for the buffer status flag block
`timescale 1ns/1ps
`default_nettype none
module dcfsf_top_sva #(parameter DATA_W = 18) (
   // clock and resets
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic MASTER_RESET_N_I,
   input wire logic PARTIAL_RESET_N_I,
   // enables and outputs
   input wire logic WRITE_EN_N_I,
   input wire logic READ_EN_N_I,
   input wire logic [DATA_W-1:0] DATA_OUT_O,
   input wire logic FULL_FLAG_N_O,
   input wire logic EMPTY_FLAG_N_O,
   input wire logic ALMOST_FULL_FLAG_N_O,
   input wire logic ALMOST_EMPTY_FLAG_N_O,
   input wire logic HALF_FULL_FLAG_N_O,
   input wire logic FALL_THROUGH_MODE_O
);
   wire clr = SYS_RST_I | ~MASTER_RESET_N_I | ~PARTIAL_RESET_N_I;
   logic clr_reg;
   logic [3:0] wr_age_reg, rd_age_reg;
   // ages saturate so a long idle never wraps round to look recent
   always @(posedge CLK_I) begin
      clr_reg <= clr;
      if (clr | ~WRITE_EN_N_I) wr_age_reg <= clr ? 4'hF : 4'h0;
      else if (wr_age_reg != 4'hF) wr_age_reg <= wr_age_reg + 4'h1;
      if (clr | ~READ_EN_N_I) rd_age_reg <= clr ? 4'hF : 4'h0;
      else if (rd_age_reg != 4'hF) rd_age_reg <= rd_age_reg + 4'h1;
   end
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (clr | clr_reg);
   sequence s_ft_hold;
      FALL_THROUGH_MODE_O && !EMPTY_FLAG_N_O && READ_EN_N_I;
   endsequence
   property p_std_hold;
      !FALL_THROUGH_MODE_O && READ_EN_N_I |=> $stable(DATA_OUT_O);
   endproperty
   a_std_hold: assert property (p_std_hold) else $error("word moved");
   property p_ft_hold;
      s_ft_hold |=> !EMPTY_FLAG_N_O && $stable(DATA_OUT_O);
   endproperty
   a_ft_hold: assert property (p_ft_hold) else $error("word lost");
   property p_ft_show;
      FALL_THROUGH_MODE_O && $fell(EMPTY_FLAG_N_O) |-> $changed(DATA_OUT_O);
   endproperty
   a_ft_show: assert property (p_ft_show) else $error("ready early");
   property p_full_keep;
      FULL_FLAG_N_O == FALL_THROUGH_MODE_O && rd_age_reg == 4'hF
         |=> $stable(FULL_FLAG_N_O);
   endproperty
   a_full_keep: assert property (p_full_keep) else $error("full left");
   property p_hf_set;
      $fell(HALF_FULL_FLAG_N_O) |-> wr_age_reg <= 4'h3;
   endproperty
   a_hf_set: assert property (p_hf_set) else $error("half set");
   property p_hf_rel;
      $rose(HALF_FULL_FLAG_N_O) |-> rd_age_reg <= 4'h9;
   endproperty
   a_hf_rel: assert property (p_hf_rel) else $error("half rel");
   property p_af_set;
      $fell(ALMOST_FULL_FLAG_N_O) |-> wr_age_reg <= 4'h3;
   endproperty
   a_af_set: assert property (p_af_set) else $error("afull set");
   property p_ae_rel;
      $rose(ALMOST_EMPTY_FLAG_N_O) |-> wr_age_reg <= 4'hA;
   endproperty
   a_ae_rel: assert property (p_ae_rel) else $error("aempty rel");
endmodule
bind dcfsf_top dcfsf_top_sva #(.DATA_W(DATA_W)) u_sva (.CLK_I, .SYS_RST_I,
   .MASTER_RESET_N_I, .PARTIAL_RESET_N_I, .WRITE_EN_N_I, .READ_EN_N_I,
   .DATA_OUT_O, .FULL_FLAG_N_O, .EMPTY_FLAG_N_O, .ALMOST_FULL_FLAG_N_O,
   .ALMOST_EMPTY_FLAG_N_O, .HALF_FULL_FLAG_N_O, .FALL_THROUGH_MODE_O);
`default_nettype wire

// *** bench/dcfsf_top_test.sv ***
// self-checking bench for the buffer status flag block
`timescale 1ns/1ps
`default_nettype none
module dcfsf_top_test;
   localparam int D = 1024;
   logic clk, rst = 1, mrst_n = 1, prst_n = 1, ld_n = 0;
   logic wr = 0, rd = 0, ft = 0, mon = 0;
   logic wen_n, ren_n, mode, full_n, empty_n, af_n, ae_n, hf_n, ftm;
   logic [17:0] din = 18'h0_0000, pin_d, dout, last = 18'h0_0000;
   logic [17:0] q[$];
   logic [31:0] r;
   int n_mismatch = 0, n_compared = 0;
   dcfsf_peer peer (.clk_i(clk), .wr_i(wr), .rd_i(rd), .ft_i(ft),
      .data_i(din), .wen_n_o(wen_n), .ren_n_o(ren_n), .mode_o(mode),
      .data_o(pin_d));
   dcfsf_top #(.DEPTH_LOG2(10)) uut (.CLK_I(clk), .SYS_RST_I(rst),
      .MASTER_RESET_N_I(mrst_n), .PARTIAL_RESET_N_I(prst_n),
      .MODE_SERIAL_IN_I(mode), .OFFSET_LOAD_N_I(ld_n),
      .WRITE_EN_N_I(wen_n), .DATA_IN_I(pin_d), .READ_EN_N_I(ren_n),
      .DATA_OUT_O(dout), .FULL_FLAG_N_O(full_n),
      .EMPTY_FLAG_N_O(empty_n), .ALMOST_FULL_FLAG_N_O(af_n),
      .ALMOST_EMPTY_FLAG_N_O(ae_n), .HALF_FULL_FLAG_N_O(hf_n),
      .FALL_THROUGH_MODE_O(ftm));
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic cmp_flag(input string s, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic cmp_data(input logic [17:0] e, input logic [17:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR data_out expected %h seen %h", e, g);
      end
   endtask
   // each new word on the output is matched against the oldest write
   always @(posedge clk) begin
      if (mon && dout !== last)
         cmp_data(q.size() > 0 ? q.pop_front() : ~dout, dout);
      last <= dout;
   end
   task automatic chk(input int c);
      int cap, m;
      cap = D + ft;
      m = ld_n ? 1023 : 127;
      cmp_flag("full", (c >= cap) == ft, full_n);
      cmp_flag("empty", (c > 0) != ft, empty_n);
      cmp_flag("almost_full", !(c >= cap - m), af_n);
      cmp_flag("almost_empty", !(c <= m + ft), ae_n);
      cmp_flag("half_full", !(c > D / 2 + ft), hf_n);
   endtask
   task automatic put(input logic [17:0] v, input logic keep);
      wr <= 1;
      din <= v;
      if (keep) q.push_back(v);
      step(1);
      wr <= 0;
      step(10);
   endtask
   task automatic take;
      rd <= 1;
      step(1);
      rd <= 0;
      step(10);
   endtask
   // fill past capacity with no reads, then drain and read once more
   task automatic run(input logic m_ft, input logic m_ld);
      int c, k;
      mon <= 0;
      ft <= m_ft;
      ld_n <= m_ld;
      step(2);
      mrst_n <= 0;
      step(4);
      mrst_n <= 1;
      step(4);
      mon <= 1;
      cmp_flag("mode", m_ft, ftm);
      c = 0;
      for (k = 1; k <= D + 2; k++) begin
         r = $urandom;
         put({r[8:0], k[8:0]}, c < D + m_ft);
         if (c < D + m_ft) c++;
         chk(c);
      end
      while (c > 0) begin
         take();
         c--;
         chk(c);
      end
      take();
      chk(0);
      $display("test done: fill and drain, mode %0d", m_ft);
   endtask
   initial begin
      r = $urandom(32'h9067999d);
      step(16);
      rst <= 0;
      run(1'b0, 1'b0);
      run(1'b1, 1'b1);
      // back-to-back writes with the reader stalled, then a read burst
      for (int k = 0; k < 4; k++) begin
         r = $urandom;
         wr <= 1;
         din <= {r[17:2], k[1:0]};
         q.push_back({r[17:2], k[1:0]});
         step(1);
      end
      wr <= 0;
      step(12);
      chk(4);
      rd <= 1;
      step(24);
      rd <= 0;
      step(10);
      chk(0);
      cmp_flag("words_left", 1'b1, q.size() == 0);
      $display("test done: bursts");
      mon <= 0;
      put(18'h1_2345, 1'b0);
      put(18'h0_0A5A, 1'b0);
      prst_n <= 0;
      step(2);
      prst_n <= 1;
      step(10);
      chk(0);
      cmp_flag("mode", 1'b1, ftm);
      $display("test done: partial reset");
      summarize();
   end
   // two fills and drains take about 45k cycles
   initial begin
      #400_000;
      n_mismatch++;
      summarize();
   end
   task automatic summarize;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
endmodule
`default_nettype wire

// *** design/dcfsf_regs.vh ***
// constants for the buffer status flag block
`ifndef DCFSF_REGS_VH
`define DCFSF_REGS_VH
// data word width
`define DCFSF_DATA_W 18
// log2 of the stored depth, 17 for 131072 words, 18 for 262144
`define DCFSF_DEPTH_LOG2 17
// width of the programmable flag offsets
`define DCFSF_OFS_W 10
// default offsets picked by the offset-load level at master reset
`define DCFSF_OFS_SHORT 10'h07F
`define DCFSF_OFS_LONG 10'h3FF
// entries of the input hold buffer
`define DCFSF_HOLD_DEPTH 2
`endif

// *** design/dcfsf_top.v ***
// status flag generation and storage of the dual-mode first-in first-out buffer
`timescale 1ns/1ps
`default_nettype none
`include "dcfsf_regs.vh"

// gray-coded pointer crossing: source register then two capture flops
module dcfsf_ptr_sync #(
   parameter W = 19
) (
   input wire clk_i,
   input wire rst_i,
   input wire [W-1:0] bin_i,
   output reg [W-1:0] bin_o
);
   reg [W-1:0] gray_reg;
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   integer k;
   always @(posedge clk_i) begin
      if (rst_i) begin
         gray_reg <= {W{1'b0}};
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         gray_reg <= bin_i ^ (bin_i >> 1);
         meta_reg <= gray_reg;
         sync_reg <= meta_reg;
      end
   end
   // decode only the second capture flop
   always @* begin
      bin_o = {W{1'b0}};
      bin_o[W-1] = sync_reg[W-1];
      for (k = W - 2; k >= 0; k = k - 1) begin
         bin_o[k] = bin_o[k+1] ^ sync_reg[k];
      end
   end
endmodule

// two-entry hold buffer, valid and ready on both sides
module dcfsf_hold_buf #(
   parameter W = 18
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // upstream side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // downstream side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o,
   // entries held
   output wire [1:0] count_o
);
   reg [W-1:0] head_reg;
   reg [W-1:0] tail_reg;
   reg [1:0] count_reg;
   wire push;
   wire pop;
   assign in_ready_o = count_reg != 2'd2;
   assign out_valid_o = count_reg != 2'd0;
   assign out_data_o = head_reg;
   assign count_o = count_reg;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   // a stalled receiver keeps both words, so none is lost
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= 2'd0;
         head_reg <= {W{1'b0}};
         tail_reg <= {W{1'b0}};
      end else begin
         case ({push, pop})
            2'b10: begin
               if (count_reg == 2'd0) begin
                  head_reg <= in_data_i;
               end else begin
                  tail_reg <= in_data_i;
               end
               count_reg <= count_reg + 2'd1;
            end
            2'b01: begin
               head_reg <= tail_reg;
               count_reg <= count_reg - 2'd1;
            end
            2'b11: begin
               if (count_reg == 2'd1) begin
                  head_reg <= in_data_i;
               end else begin
                  head_reg <= tail_reg;
                  tail_reg <= in_data_i;
               end
            end
            default: begin
               count_reg <= count_reg;
            end
         endcase
      end
   end
endmodule

module dcfsf_top #(
   parameter DATA_W = `DCFSF_DATA_W,
   parameter DEPTH_LOG2 = `DCFSF_DEPTH_LOG2
) (
   // clock and reset
   input wire CLK_I,
   input wire SYS_RST_I,
   input wire MASTER_RESET_N_I,
   input wire PARTIAL_RESET_N_I,
   // straps sampled during master reset
   input wire MODE_SERIAL_IN_I,
   input wire OFFSET_LOAD_N_I,
   // write port
   input wire WRITE_EN_N_I,
   input wire [DATA_W-1:0] DATA_IN_I,
   // read port
   input wire READ_EN_N_I,
   output reg [DATA_W-1:0] DATA_OUT_O,
   // status flags
   output reg FULL_FLAG_N_O,
   output reg EMPTY_FLAG_N_O,
   output reg ALMOST_FULL_FLAG_N_O,
   output reg ALMOST_EMPTY_FLAG_N_O,
   output reg HALF_FULL_FLAG_N_O,
   output reg FALL_THROUGH_MODE_O
);
   localparam PW = DEPTH_LOG2 + 2;
   localparam OW = `DCFSF_OFS_W;

   reg [DATA_W-1:0] mem [0:(1<<DEPTH_LOG2)-1];

   reg fall_through_mode_reg;
   reg long_ofs_reg;
   wire clear;
   wire [PW-1:0] dep;
   wire [PW-1:0] ft;
   wire [PW-1:0] cap;
   wire [PW-1:0] hth;
   wire [OW-1:0] ofs;
   wire [PW-1:0] ofs_ext;

   // write side state
   reg [PW-1:0] wptr_reg;
   wire [DATA_W-1:0] hold_word;
   wire [1:0] hold_cnt;
   wire hold_in_valid;
   wire hold_out_valid;
   reg full_stage_reg;
   wire [PW-1:0] rdone_w;
   wire [PW-1:0] rmem_w;
   wire [PW-1:0] mem_used_w;
   wire [PW-1:0] tot_w;
   wire [PW-1:0] tot_after;
   wire mem_room;
   wire hold_ready;
   wire drain;
   wire accept;
   wire full_int;
   wire full_after;
   wire w_over;

   // read side state
   reg [PW-1:0] mrptr_reg;
   reg [PW-1:0] rdone_reg;
   reg [PW-1:0] wptr_r3_reg;
   reg out_valid_reg;
   wire [PW-1:0] wptr_r;
   wire [PW-1:0] wsel;
   wire [PW-1:0] avail;
   wire [PW-1:0] cnt_r;
   wire [PW-1:0] cnt_r_after;
   wire [PW-1:0] pae_thr;
   wire std_rd;
   wire ft_load;
   wire ft_rd;
   wire take;
   wire done;
   wire out_valid_next;
   wire empty_level;
   wire r_under;

   assign clear = SYS_RST_I | ~MASTER_RESET_N_I | ~PARTIAL_RESET_N_I;
   assign dep = {2'b01, {DEPTH_LOG2{1'b0}}};
   assign ft = {{(PW-1){1'b0}}, fall_through_mode_reg};
   // one extra slot is the output register in fall-through mode
   assign cap = dep + ft;
   assign hth = {1'b0, dep[PW-1:1]} + ft;
   assign ofs = long_ofs_reg ? `DCFSF_OFS_LONG : `DCFSF_OFS_SHORT;
   assign ofs_ext = {{(PW-OW){1'b0}}, ofs};

   // straps are caught while master reset is held, kept through partial
   always @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         fall_through_mode_reg <= 1'b0;
         long_ofs_reg <= 1'b0;
      end else if (!MASTER_RESET_N_I) begin
         fall_through_mode_reg <= MODE_SERIAL_IN_I;
         long_ofs_reg <= OFFSET_LOAD_N_I;
      end
   end

   dcfsf_ptr_sync #(.W(PW)) u_rdone_sync (
      .clk_i(CLK_I),
      .rst_i(clear),
      .bin_i(rdone_reg),
      .bin_o(rdone_w)
   );
   dcfsf_ptr_sync #(.W(PW)) u_rmem_sync (
      .clk_i(CLK_I),
      .rst_i(clear),
      .bin_i(mrptr_reg),
      .bin_o(rmem_w)
   );
   dcfsf_ptr_sync #(.W(PW)) u_wptr_sync (
      .clk_i(CLK_I),
      .rst_i(clear),
      .bin_i(wptr_reg),
      .bin_o(wptr_r)
   );

   // write side: stale read pointers only overstate fill, never overflow
   assign mem_used_w = wptr_reg - rmem_w;
   assign mem_room = mem_used_w < dep;
   assign drain = hold_out_valid & mem_room;
   assign tot_w = wptr_reg + {{(PW-2){1'b0}}, hold_cnt} - rdone_w;
   assign full_int = tot_w >= cap;
   assign hold_in_valid = ~WRITE_EN_N_I & ~full_int;
   assign accept = hold_in_valid & hold_ready;
   assign tot_after = tot_w + {{(PW-1){1'b0}}, accept};
   assign full_after = tot_after >= cap;
   assign w_over = accept & (tot_after > hth);

   // hold buffer: stalls when the array has no room during a handoff
   dcfsf_hold_buf #(.W(DATA_W)) u_hold (
      .clk_i(CLK_I),
      .rst_i(clear),
      .in_valid_i(hold_in_valid),
      .in_ready_o(hold_ready),
      .in_data_i(DATA_IN_I),
      .out_valid_o(hold_out_valid),
      .out_ready_i(mem_room),
      .out_data_o(hold_word),
      .count_o(hold_cnt)
   );

   always @(posedge CLK_I) begin
      if (clear) begin
         wptr_reg <= {PW{1'b0}};
      end else if (drain) begin
         wptr_reg <= wptr_reg + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge CLK_I) begin
      if (drain) begin
         mem[wptr_reg[DEPTH_LOG2-1:0]] <= hold_word;
      end
   end

   // full/input-ready: two stages, polarity by mode
   always @(posedge CLK_I) begin
      if (clear) begin
         full_stage_reg <= ~fall_through_mode_reg;
         FULL_FLAG_N_O <= ~fall_through_mode_reg;
         ALMOST_FULL_FLAG_N_O <= 1'b1;
      end else begin
         full_stage_reg <= fall_through_mode_reg ? full_after
                                                 : ~full_after;
         FULL_FLAG_N_O <= full_stage_reg;
         ALMOST_FULL_FLAG_N_O <= ~(tot_after >= cap - ofs_ext);
      end
   end

   // read side: fall-through sees the write pointer one stage later
   always @(posedge CLK_I) begin
      if (clear) begin
         wptr_r3_reg <= {PW{1'b0}};
      end else begin
         wptr_r3_reg <= wptr_r;
      end
   end

   assign wsel = fall_through_mode_reg ? wptr_r3_reg : wptr_r;
   assign avail = wsel - mrptr_reg;
   assign std_rd = ~READ_EN_N_I & (avail != {PW{1'b0}});
   assign ft_load = (avail != {PW{1'b0}}) & (~out_valid_reg | ~READ_EN_N_I);
   assign ft_rd = out_valid_reg & ~READ_EN_N_I;
   assign take = fall_through_mode_reg ? ft_load : std_rd;
   assign done = fall_through_mode_reg ? ft_rd : std_rd;
   assign out_valid_next = ft_load | (out_valid_reg & ~ft_rd);
   // count includes the output register word in fall-through mode
   assign cnt_r = wsel - rdone_reg;
   assign cnt_r_after = cnt_r - {{(PW-1){1'b0}}, done};
   assign pae_thr = ofs_ext + ft;
   assign empty_level = (avail - {{(PW-1){1'b0}}, std_rd}) != {PW{1'b0}};
   assign r_under = done & (cnt_r_after <= hth);

   always @(posedge CLK_I) begin
      if (clear) begin
         mrptr_reg <= {PW{1'b0}};
         rdone_reg <= {PW{1'b0}};
         out_valid_reg <= 1'b0;
         EMPTY_FLAG_N_O <= fall_through_mode_reg;
         ALMOST_EMPTY_FLAG_N_O <= 1'b0;
      end else begin
         if (take) begin
            mrptr_reg <= mrptr_reg + {{(PW-1){1'b0}}, 1'b1};
         end
         if (done) begin
            rdone_reg <= rdone_reg + {{(PW-1){1'b0}}, 1'b1};
         end
         out_valid_reg <= out_valid_next;
         if (fall_through_mode_reg) begin
            EMPTY_FLAG_N_O <= ~out_valid_next;
         end else begin
            EMPTY_FLAG_N_O <= empty_level;
         end
         ALMOST_EMPTY_FLAG_N_O <= cnt_r_after > pae_thr;
      end
   end

   // data out keeps its last word when nothing is taken
   always @(posedge CLK_I) begin
      if (clear) begin
         DATA_OUT_O <= {DATA_W{1'b0}};
      end else if (take) begin
         DATA_OUT_O <= mem[mrptr_reg[DEPTH_LOG2-1:0]];
      end
   end

   // half-full: set by writes, released by reads; the write event wins
   always @(posedge CLK_I) begin
      if (clear) begin
         HALF_FULL_FLAG_N_O <= 1'b1;
         FALL_THROUGH_MODE_O <= 1'b0;
      end else begin
         if (w_over) begin
            HALF_FULL_FLAG_N_O <= 1'b0;
         end else if (r_under) begin
            HALF_FULL_FLAG_N_O <= 1'b1;
         end
         FALL_THROUGH_MODE_O <= fall_through_mode_reg;
      end
   end
endmodule
`default_nettype wire
